// [bridge_cfg_regs.sv]
// Configuration register bank of the display bridge.
`timescale 1ns/1ps
module bridge_cfg_regs
  import bridge_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  cfg_link_if.device link,
  input wire logic de_active,
  input wire logic line_sync_active,
  input wire logic frame_sync_active,
  output logic pixel_clock_source_sel,
  output logic [4:0] pixel_clock_divisor,
  output logic pixel_clock_div_reserved,
  output logic [2:0] ext_clock_multiplier,
  output logic [2:0] lvds_clock_band,
  output logic pll_enable,
  output logic rx_split_left_right,
  output rx_mode_t rx_channel_mode,
  output logic [2:0] rx_a_lane_count,
  output logic [2:0] rx_b_lane_count,
  output logic leader_strict_check,
  output logic [1:0] rx_a_data_equalize,
  output logic [1:0] rx_b_data_equalize,
  output logic [1:0] rx_a_clock_equalize,
  output logic [1:0] rx_b_clock_equalize,
  output logic [7:0] rx_a_clock_band,
  output logic [7:0] rx_b_clock_band,
  output logic rx_a_band_valid,
  output logic rx_b_band_valid,
  output logic de_out,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic out_b_enable,
  output logic out_dual_link,
  output logic out_two_single,
  output logic out_a_wide_color,
  output logic out_b_wide_color,
  output logic out_a_lsb_lane_format,
  output logic out_b_lsb_lane_format,
  output logic out_a_drop_lsb,
  output logic out_b_drop_lsb,
  output logic [7:0] drive_level,
  output logic soft_reset_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0] clk_src;
    logic [7:0] divmul;
    logic [7:0] pll;
    logic [7:0] rx_cfg;
    logic [7:0] rx_eq;
    logic [7:0] band_a;
    logic [7:0] band_b;
    logic [7:0] out_fmt;
    logic [7:0] drive;
    logic [7:0] rdata;
    logic ack;
    logic soft_rst;
    logic de;
    logic line_sync;
    logic frame_sync;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{
    clk_src: RST_CLOCK_SRC,
    divmul: RST_DIVMUL,
    pll: RST_PLL,
    rx_cfg: RST_RX_CFG,
    rx_eq: RST_RX_EQ,
    band_a: RST_BAND,
    band_b: RST_BAND,
    out_fmt: RST_OUT_FMT,
    drive: RST_DRIVE,
    rdata: 8'h00,
    ack: 1'b0,
    soft_rst: 1'b0,
    de: 1'b0,
    line_sync: 1'b0,
    frame_sync: 1'b0
  };

  dev_state_t s_q;
  dev_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Field decoders.

  // Lane code 00 means four lanes, 11 means one.
  function automatic logic [2:0] lane_count(input logic [1:0] code);
    lane_count = 3'h4 - {1'b0, code};
  endfunction : lane_count

  // Equalization in dB; the reserved code reads as none.
  function automatic logic [1:0] eq_db(input logic [1:0] code);
    eq_db = (code == 2'h1) ? 2'h1 : ((code == 2'h3) ? 2'h2 : 2'h0);
  endfunction : eq_db

  function automatic logic band_ok(input logic [7:0] code);
    band_ok = (code >= BAND_MIN) && (code <= BAND_MAX);
  endfunction : band_ok

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    logic [7:0] rd;
    rd = 8'h00;
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.soft_rst = 1'b0;
    s_d.de = de_active ^ s_q.out_fmt[DE_INV_BIT];
    s_d.line_sync = line_sync_active ^ s_q.out_fmt[LINE_INV_BIT];
    s_d.frame_sync = frame_sync_active ^ s_q.out_fmt[FRAME_INV_BIT];
    if (link.addr == REG_CLOCK_SRC)
    begin
      rd = s_q.clk_src;
      rd[PLL_STAT_BIT] = s_q.pll[PLL_EN_BIT];
    end
    else if (link.addr == REG_DIVMUL)
    begin
      rd = s_q.divmul;
    end
    else if (link.addr == REG_PLL)
    begin
      rd = s_q.pll;
    end
    else if (link.addr == REG_RX_CFG)
    begin
      rd = s_q.rx_cfg;
    end
    else if (link.addr == REG_RX_EQ)
    begin
      rd = s_q.rx_eq;
    end
    else if (link.addr == REG_RX_A_BAND)
    begin
      rd = s_q.band_a;
    end
    else if (link.addr == REG_RX_B_BAND)
    begin
      rd = s_q.band_b;
    end
    else if (link.addr == REG_OUT_FMT)
    begin
      rd = s_q.out_fmt;
    end
    else if (link.addr == REG_DRIVE)
    begin
      rd = s_q.drive;
    end
    if (link.req && !s_q.ack)
    begin
      s_d.ack = 1'b1;
      s_d.rdata = rd;
      if (link.we)
      begin
        if (link.addr == REG_RESET_CTRL)
        begin
          s_d.soft_rst = link.wdata[SOFT_RESET_BIT];
        end
        else if (link.addr == REG_CLOCK_SRC)
        begin
          s_d.clk_src = link.wdata & MASK_CLOCK_SRC;
        end
        else if (link.addr == REG_DIVMUL)
        begin
          s_d.divmul = link.wdata & MASK_DIVMUL;
        end
        else if (link.addr == REG_PLL)
        begin
          s_d.pll = link.wdata & MASK_PLL;
        end
        else if (link.addr == REG_RX_CFG)
        begin
          s_d.rx_cfg = link.wdata;
        end
        else if (link.addr == REG_RX_EQ)
        begin
          s_d.rx_eq = link.wdata;
        end
        else if (link.addr == REG_RX_A_BAND)
        begin
          s_d.band_a = link.wdata;
        end
        else if (link.addr == REG_RX_B_BAND)
        begin
          s_d.band_b = link.wdata;
        end
        else if (link.addr == REG_OUT_FMT)
        begin
          s_d.out_fmt = link.wdata;
        end
        else if (link.addr == REG_DRIVE)
        begin
          s_d.drive = link.wdata & MASK_DRIVE;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= DEV_RESET;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  logic [4:0] div_code;
  logic [1:0] mul_code;
  logic [1:0] mode_code;

  assign div_code = s_q.divmul[DIV_LSB +: 5];
  assign mul_code = s_q.divmul[MUL_LSB +: 2];
  assign mode_code = s_q.rx_cfg[MODE_LSB +: 2];

  assign link.ack = s_q.ack;
  assign link.rdata = s_q.rdata;
  assign pixel_clock_source_sel = s_q.clk_src[SRC_BIT];
  assign pixel_clock_div_reserved = pixel_clock_source_sel && (div_code > DIV_MAX);
  assign pixel_clock_divisor = (pixel_clock_source_sel && !pixel_clock_div_reserved) ?
    5'(div_code + 5'h01) : 5'h01;
  assign ext_clock_multiplier = pixel_clock_source_sel ? 3'h1 :
    3'({1'b0, mul_code} + 3'h1);
  assign lvds_clock_band = s_q.clk_src[RANGE_LSB +: 3];
  assign pll_enable = s_q.pll[PLL_EN_BIT];
  assign rx_split_left_right = s_q.rx_cfg[SPLIT_BIT];
  assign rx_channel_mode = rx_mode_t'(mode_code);
  assign rx_a_lane_count = lane_count(s_q.rx_cfg[LANES_A_LSB +: 2]);
  assign rx_b_lane_count = lane_count(s_q.rx_cfg[LANES_B_LSB +: 2]);
  assign leader_strict_check = s_q.rx_cfg[STRICT_BIT];
  assign rx_a_data_equalize = eq_db(s_q.rx_eq[EQ_A_DATA_LSB +: 2]);
  assign rx_b_data_equalize = eq_db(s_q.rx_eq[EQ_B_DATA_LSB +: 2]);
  assign rx_a_clock_equalize = eq_db(s_q.rx_eq[EQ_A_CLK_LSB +: 2]);
  assign rx_b_clock_equalize = eq_db(s_q.rx_eq[EQ_B_CLK_LSB +: 2]);
  assign rx_a_clock_band = s_q.band_a;
  assign rx_b_clock_band = s_q.band_b;
  assign rx_a_band_valid = band_ok(s_q.band_a);
  assign rx_b_band_valid = band_ok(s_q.band_b);
  assign de_out = s_q.de;
  assign line_sync_out = s_q.line_sync;
  assign frame_sync_out = s_q.frame_sync;
  assign out_b_enable = !s_q.out_fmt[LINK_BIT];
  assign out_dual_link = out_b_enable && (mode_code != RX_TWO_SINGLE);
  assign out_two_single = out_b_enable && (mode_code == RX_TWO_SINGLE);
  assign out_a_wide_color = s_q.out_fmt[WIDE_A_BIT];
  assign out_b_wide_color = s_q.out_fmt[WIDE_B_BIT];
  assign out_a_lsb_lane_format = s_q.out_fmt[FMT_A_BIT];
  assign out_b_lsb_lane_format = s_q.out_fmt[FMT_B_BIT];
  assign out_a_drop_lsb = out_a_lsb_lane_format && !out_a_wide_color;
  assign out_b_drop_lsb = out_b_lsb_lane_format && !out_b_wide_color;
  assign drive_level = s_q.drive;
  assign soft_reset_pulse = s_q.soft_rst;

endmodule : bridge_cfg_regs

// [bridge_cfg_pkg.sv]
// Constants and types shared by the configuration bank and its controller.
package bridge_cfg_pkg;
  localparam logic [7:0] REG_RESET_CTRL = 8'h09;
  localparam logic [7:0] REG_CLOCK_SRC = 8'h0A;
  localparam logic [7:0] REG_DIVMUL = 8'h0B;
  localparam logic [7:0] REG_PLL = 8'h0D;
  localparam logic [7:0] REG_RX_CFG = 8'h10;
  localparam logic [7:0] REG_RX_EQ = 8'h11;
  localparam logic [7:0] REG_RX_A_BAND = 8'h12;
  localparam logic [7:0] REG_RX_B_BAND = 8'h13;
  localparam logic [7:0] REG_OUT_FMT = 8'h18;
  localparam logic [7:0] REG_DRIVE = 8'h19;
  localparam logic [7:0] RST_CLOCK_SRC = 8'h0A;
  localparam logic [7:0] RST_DIVMUL = 8'h00;
  localparam logic [7:0] RST_PLL = 8'h00;
  localparam logic [7:0] RST_RX_CFG = 8'h3E;
  localparam logic [7:0] RST_RX_EQ = 8'h00;
  localparam logic [7:0] RST_BAND = 8'h00;
  localparam logic [7:0] RST_OUT_FMT = 8'h70;
  localparam logic [7:0] RST_DRIVE = 8'h05;
  localparam logic [7:0] MASK_CLOCK_SRC = 8'h0F;
  localparam logic [7:0] MASK_DIVMUL = 8'hFB;
  localparam logic [7:0] MASK_PLL = 8'h01;
  localparam logic [7:0] MASK_DRIVE = 8'h5F;
  localparam logic [7:0] MASK_DIV_FIELD = 8'hF8;
  localparam logic [7:0] MASK_MUL_FIELD = 8'h03;
  localparam logic [7:0] MASK_FORMAT_BITS = 8'h03;
  localparam logic [7:0] SOFT_RESET_CMD = 8'h01;
  localparam int SRC_BIT = 0;
  localparam int PLL_STAT_BIT = 7;
  localparam int PLL_EN_BIT = 0;
  localparam int SOFT_RESET_BIT = 0;
  localparam int DIV_LSB = 3;
  localparam int MUL_LSB = 0;
  localparam int RANGE_LSB = 1;
  localparam int SPLIT_BIT = 7;
  localparam int MODE_LSB = 5;
  localparam int LANES_A_LSB = 3;
  localparam int LANES_B_LSB = 1;
  localparam int STRICT_BIT = 0;
  localparam int EQ_A_DATA_LSB = 6;
  localparam int EQ_B_DATA_LSB = 4;
  localparam int EQ_A_CLK_LSB = 2;
  localparam int EQ_B_CLK_LSB = 0;
  localparam int DE_INV_BIT = 7;
  localparam int LINE_INV_BIT = 6;
  localparam int FRAME_INV_BIT = 5;
  localparam int LINK_BIT = 4;
  localparam int WIDE_A_BIT = 3;
  localparam int WIDE_B_BIT = 2;
  localparam int FMT_A_BIT = 1;
  localparam int FMT_B_BIT = 0;
  localparam logic [4:0] DIV_MAX = 5'h18;
  localparam logic [7:0] BAND_MIN = 8'h08;
  localparam logic [7:0] BAND_MAX = 8'h64;
  localparam logic [7:0] HOST_TARGET = 8'h00;
  localparam logic [7:0] HOST_WDATA = 8'h04;
  localparam logic [7:0] HOST_CTRL = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0C;
  localparam int GO_WRITE_BIT = 0;
  localparam int GO_READ_BIT = 1;
  localparam int GO_SOFT_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PLL_LOCK_MS = 3;
  localparam int CLOCK_KHZ = 40000;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_MS * CLOCK_KHZ;
  typedef enum logic [1:0] {
    RX_DUAL = 2'b00,
    RX_SINGLE = 2'b01,
    RX_TWO_SINGLE = 2'b10,
    RX_RESERVED = 2'b11
  } rx_mode_t;
  typedef enum logic {
    HOST_IDLE = 1'b0,
    HOST_REQ = 1'b1
  } host_state_t;
endpackage : bridge_cfg_pkg

// [cfg_link_if.sv]
// Register access link between the controller and the configuration bank.
`timescale 1ns/1ps
interface cfg_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
  modport device (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface : cfg_link_if

// [bridge_cfg_host.sv]
// Controller that issues register accesses to the bridge on software command.
`timescale 1ns/1ps
module bridge_cfg_host
  import bridge_cfg_pkg::*;
#(
  parameter int LOCK_WAIT_CYCLES = PLL_LOCK_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  cfg_link_if.host link,
  input wire logic stream_is_18bpp,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    host_state_t st;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] target;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic refused;
    logic src_chan_a;
    logic pll_on;
    logic [16:0] lock_cnt;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } host_reg_t;

  host_reg_t s_q;
  host_reg_t s_d;

  logic pll_ready;

  assign pll_ready = s_q.pll_on && (s_q.lock_cnt == 17'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    logic [7:0] a;
    logic [7:0] d;
    logic w;
    a = s_q.target;
    d = s_q.tx_byte;
    w = 1'b0;
    s_d = s_q;
    if (s_q.lock_cnt != 17'h0)
    begin
      s_d.lock_cnt = s_q.lock_cnt - 17'h1;
    end
    if (awvalid && awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      s_d.w_got = 1'b1;
      s_d.w_byte = wdata[7:0];
      s_d.w_lane = wstrb[0];
    end
    if (bvalid && bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (rvalid && rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.st == HOST_REQ && link.ack)
    begin
      s_d.st = HOST_IDLE;
      s_d.req = 1'b0;
      s_d.rx_byte = link.rdata;
    end
    if (arvalid && arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0;
      if (araddr == HOST_TARGET)
      begin
        s_d.rdata[7:0] = s_q.target;
      end
      else if (araddr == HOST_WDATA)
      begin
        s_d.rdata[7:0] = s_q.tx_byte;
      end
      else if (araddr == HOST_STATUS)
      begin
        s_d.rdata = {16'h0, s_q.rx_byte, 5'h0, pll_ready, s_q.refused, s_q.st};
      end
      else if (araddr != HOST_CTRL)
      begin
        s_d.rresp = RESP_SLVERR;
      end
    end
    if (s_q.aw_got && s_q.w_got)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (!s_q.w_lane)
      begin
        s_d.bresp = RESP_OKAY;
      end
      else if (s_q.aw_addr == HOST_TARGET)
      begin
        s_d.target = s_q.w_byte;
      end
      else if (s_q.aw_addr == HOST_WDATA)
      begin
        s_d.tx_byte = s_q.w_byte;
      end
      else if (s_q.aw_addr == HOST_CTRL)
      begin
        if (s_q.w_byte[GO_SOFT_BIT])
        begin
          a = REG_RESET_CTRL;
          d = SOFT_RESET_CMD;
          w = 1'b1;
        end
        else
        begin
          w = s_q.w_byte[GO_WRITE_BIT];
        end
        if (a == REG_DIVMUL)
        begin
          d = s_q.src_chan_a ? (d & ~MASK_MUL_FIELD) : (d & ~MASK_DIV_FIELD);
        end
        if (a == REG_OUT_FMT && stream_is_18bpp)
        begin
          d = d & ~MASK_FORMAT_BITS;
        end
        if ((s_q.w_byte & 8'h07) == 8'h00)
        begin
          s_d.refused = s_q.refused;
        end
        else if (s_q.st != HOST_IDLE)
        begin
          s_d.refused = 1'b1;
        end
        else if (w && s_q.pll_on && (a == REG_CLOCK_SRC || a == REG_DIVMUL ||
          a == REG_RX_A_BAND))
        begin
          s_d.refused = 1'b1;
        end
        else
        begin
          s_d.refused = 1'b0;
          s_d.st = HOST_REQ;
          s_d.req = 1'b1;
          s_d.we = w;
          s_d.addr = a;
          s_d.data = d;
          if (w && a == REG_CLOCK_SRC)
          begin
            s_d.src_chan_a = d[SRC_BIT];
          end
          if (w && a == REG_PLL)
          begin
            s_d.pll_on = d[PLL_EN_BIT];
            s_d.lock_cnt = d[PLL_EN_BIT] ? 17'(LOCK_WAIT_CYCLES) : 17'h0;
          end
        end
      end
      else if (s_q.aw_addr != HOST_STATUS)
      begin
        s_d.bresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign awready = ce && !s_q.aw_got && !s_q.bvalid;
  assign wready = ce && !s_q.w_got && !s_q.bvalid;
  assign arready = ce && !s_q.rvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rresp = s_q.rresp;
  assign rdata = s_q.rdata;
  assign link.req = s_q.req;
  assign link.we = s_q.we;
  assign link.addr = s_q.addr;
  assign link.wdata = s_q.data;

endmodule : bridge_cfg_host

// [bridge_link_sva.sv]
// Assertions on the register link between controller and configuration bank.
`timescale 1ns/1ps
module bridge_link_sva
  import bridge_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  logic mapped;
  assign mapped = addr inside {REG_CLOCK_SRC, REG_DIVMUL, REG_PLL, REG_RX_CFG, REG_RX_EQ,
    REG_RX_A_BAND, REG_RX_B_BAND, REG_OUT_FMT, REG_DRIVE};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  ack_one_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property ($rose(req) |=> ack)
    else $error("ack not one cycle after request");
  ack_has_cause_a: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without pending request");
  req_held_a: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("request changed before ack");
  req_release_a: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  rdata_hold_a: assert property (!ack |-> $stable(rdata))
    else $error("read data moved outside ack");
  unmapped_zero_a: assert property (ack && !we && !mapped |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (ack && !we |->
    (addr != REG_DIVMUL || !rdata[2]) && (addr != REG_PLL || rdata[7:1] == 7'h00) &&
    (addr != REG_DRIVE || (!rdata[7] && !rdata[5])))
    else $error("reserved bit read nonzero");
  ////////////////////////////////////////////////////////////////////////////////
  write_seen_c: cover property (ack && we);
  read_seen_c: cover property (ack && !we && mapped);
  unmapped_seen_c: cover property (ack && !we && !mapped);
endmodule : bridge_link_sva

// [tb_dsi_lvds_bridge_config_regs.sv]
// Self-checking bench for the bridge configuration controller and bank.
`timescale 1ns/1ps
module tb_dsi_lvds_bridge_config_regs
  import bridge_cfg_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, stream_is_18bpp = 1'b0;
  logic de_active = 1'b0, line_sync_active = 1'b0, frame_sync_active = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rb;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, brsp, rrs, rx_a_data_equalize, rx_b_data_equalize;
  logic [1:0] rx_a_clock_equalize, rx_b_clock_equalize;
  logic [2:0] ext_clock_multiplier, lvds_clock_band, rx_a_lane_count, rx_b_lane_count;
  logic [4:0] pixel_clock_divisor;
  logic [7:0] rx_a_clock_band, rx_b_clock_band, drive_level;
  logic pixel_clock_source_sel, pixel_clock_div_reserved, pll_enable, rx_split_left_right;
  logic leader_strict_check, rx_a_band_valid, rx_b_band_valid, de_out, line_sync_out;
  logic frame_sync_out, out_b_enable, out_dual_link, out_two_single, out_a_wide_color;
  logic out_b_wide_color, out_a_lsb_lane_format, out_b_lsb_lane_format, out_a_drop_lsb;
  logic out_b_drop_lsb, soft_reset_pulse;
  rx_mode_t rx_channel_mode;
  int n_fail = 0, check_count = 0, cyc = 0, n_soft = 0;
  logic [7:0] ra [7] = '{8'h0B, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h18};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h3E, 8'h00, 8'h00, 8'h00, 8'h70};
  logic [7:0] cv [3] = '{8'hC3, 8'h36, 8'h00};
  logic [7:0] ev [2] = '{8'h1B, 8'hE4};
  logic [7:0] bv [4] = '{8'h07, 8'h08, 8'h64, 8'h65};
  logic [3:0] bok = 4'b0110;
  cfg_link_if cfg_link_if_i ();
  bridge_cfg_regs bridge_cfg_regs_i (.link(cfg_link_if_i), .*);
  bridge_cfg_host #(.LOCK_WAIT_CYCLES(8)) bridge_cfg_host_i (.link(cfg_link_if_i), .*);
  bridge_link_sva bridge_link_sva_i (.aclk(aclk), .aresetn(aresetn),
    .req(cfg_link_if_i.req), .we(cfg_link_if_i.we), .addr(cfg_link_if_i.addr),
    .wdata(cfg_link_if_i.wdata), .rdata(cfg_link_if_i.rdata), .ack(cfg_link_if_i.ack));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (soft_reset_pulse === 1'b1) n_soft++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic aw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    brsp = bresp;
    bready <= 1'b0;
  endtask : aw
  task automatic ar(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rdv = rdata;
    rrs = rresp;
    rready <= 1'b0;
  endtask : ar
  task automatic idle;
    do ar(HOST_STATUS);
    while (rdv[0] !== 1'b0);
  endtask : idle
  task automatic lw(input logic [7:0] a, input logic [7:0] v);
    aw(HOST_TARGET, {24'h0, a});
    aw(HOST_WDATA, {24'h0, v});
    aw(HOST_CTRL, 32'h1);
    idle();
  endtask : lw
  task automatic lr(input logic [7:0] a);
    aw(HOST_TARGET, {24'h0, a});
    aw(HOST_CTRL, 32'h2);
    idle();
    rb = rdv[15:8];
  endtask : lr
  function automatic logic [1:0] db(input logic [1:0] c);
    return (c == 2'h1) ? 2'h1 : (c == 2'h3) ? 2'h2 : 2'h0;
  endfunction : db
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    de_active <= 1'b1;
    line_sync_active <= 1'b1;
    foreach (ra[i])
    begin
      lr(ra[i]);
      chk("reset value", rb, rv[i]);
    end
    chk("source", pixel_clock_source_sel, 1'b0);
    chk("pll", pll_enable, 1'b0);
    chk("mode", rx_channel_mode, RX_SINGLE);
    chk("lanes", rx_a_lane_count, 3'h1);
    chk("range", lvds_clock_band, 3'h5);
    chk("link", out_b_enable, 1'b0);
    $display("end of test reset");
    lw(REG_DIVMUL, 8'hFF);
    lr(REG_DIVMUL);
    chk("divmul", rb, 8'h03);
    chk("mul", ext_clock_multiplier, 3'h4);
    lw(REG_CLOCK_SRC, 8'h01);
    lw(REG_DIVMUL, 8'hC3);
    lr(REG_DIVMUL);
    chk("divmul", rb, 8'hC0);
    chk("div", pixel_clock_divisor, 5'h19);
    chk("mul", ext_clock_multiplier, 3'h1);
    lw(REG_DIVMUL, 8'hC8);
    chk("div rsv", pixel_clock_div_reserved, 1'b1);
    lw(REG_PLL, 8'h01);
    chk("pll", pll_enable, 1'b1);
    chk("locking", rdv[2], 1'b0);
    lr(REG_CLOCK_SRC);
    chk("pll stat", rb, 8'h81);
    aw(HOST_TARGET, {24'h0, REG_DIVMUL});
    aw(HOST_CTRL, 32'h1);
    ar(HOST_STATUS);
    chk("refused", rdv[1], 1'b1);
    repeat (20) @(posedge aclk);
    ar(HOST_STATUS);
    chk("lock", rdv[2], 1'b1);
    lw(REG_PLL, 8'h00);
    $display("end of test clocks");
    foreach (cv[i])
    begin
      lw(REG_RX_CFG, cv[i]);
      lr(REG_RX_CFG);
      chk("rx cfg", rb, cv[i]);
      chk("split", rx_split_left_right, cv[i][7]);
      chk("mode", rx_channel_mode, cv[i][6:5]);
      chk("lanes a", rx_a_lane_count, 3'h4 - cv[i][4:3]);
      chk("lanes b", rx_b_lane_count, 3'h4 - cv[i][2:1]);
      chk("strict", leader_strict_check, cv[i][0]);
    end
    foreach (ev[i])
    begin
      lw(REG_RX_EQ, ev[i]);
      chk("eq ad", rx_a_data_equalize, db(ev[i][7:6]));
      chk("eq bd", rx_b_data_equalize, db(ev[i][5:4]));
      chk("eq ac", rx_a_clock_equalize, db(ev[i][3:2]));
      chk("eq bc", rx_b_clock_equalize, db(ev[i][1:0]));
    end
    foreach (bv[i])
    begin
      lw(REG_RX_A_BAND, bv[i]);
      lw(REG_RX_B_BAND, bv[i]);
      chk("band", rx_a_clock_band, bv[i]);
      chk("band bv", rx_b_clock_band, bv[i]);
      chk("band a", rx_a_band_valid, bok[i]);
      chk("band b", rx_b_band_valid, bok[i]);
    end
    $display("end of test receiver");
    lw(REG_OUT_FMT, 8'h8F);
    chk("de", de_out, 1'b0);
    chk("line", line_sync_out, 1'b1);
    chk("dual", out_dual_link, 1'b1);
    chk("frame", frame_sync_out, 1'b0);
    lw(REG_RX_CFG, 8'h40);
    chk("two", {out_dual_link, out_two_single}, 2'h1);
    chk("wide", {out_a_wide_color, out_b_wide_color}, 2'h3);
    chk("fmt", {out_a_lsb_lane_format, out_b_lsb_lane_format}, 2'h3);
    lw(REG_OUT_FMT, 8'h63);
    chk("de", de_out, 1'b1);
    chk("line", line_sync_out, 1'b0);
    chk("drop", {out_a_drop_lsb, out_b_drop_lsb}, 2'h3);
    chk("frame", frame_sync_out, 1'b1);
    stream_is_18bpp <= 1'b1;
    lw(REG_OUT_FMT, 8'h73);
    lr(REG_OUT_FMT);
    chk("fmt 18", rb, 8'h70);
    chk("link", out_b_enable, 1'b0);
    $display("end of test output");
    lw(REG_DRIVE, 8'hFF);
    lr(REG_DRIVE);
    chk("drive", rb, 8'h5F);
    chk("drive out", drive_level, 8'h5F);
    lr(8'h30);
    chk("unmapped", rb, 8'h00);
    ar(8'h40);
    chk("rresp", rrs, RESP_SLVERR);
    aw(8'h40, 32'h1);
    chk("bresp", brsp, RESP_SLVERR);
    wstrb <= 4'h0;
    aw(HOST_WDATA, 32'h11);
    wstrb <= 4'hF;
    ar(HOST_WDATA);
    chk("strobe", rdv, 32'hFF);
    aw(HOST_CTRL, 32'h4);
    idle();
    chk("soft", n_soft, 1);
    lr(REG_DRIVE);
    chk("kept", rb, 8'h5F);
    $display("end of test access");
    results();
  end
endmodule : tb_dsi_lvds_bridge_config_regs
